// File: logic/amd_pkg.sv
package amd_pkg;

    // ********************************************************
    // stream and opcode constants
    // ********************************************************
    localparam logic [7:0] PAGE2_PREFIX = 8'h18;
    localparam logic [7:0] XFER_OPCODE  = 8'h1E;
    localparam logic [7:0] LOOP_OPCODE  = 8'h1F;
    localparam logic [3:0] COL_REL      = 4'h2;
    localparam logic [3:0] COL_IMM_LO   = 4'h8;
    localparam logic [3:0] COL_DIR_LO   = 4'h9;
    localparam logic [3:0] COL_IDX_LO   = 4'hA;
    localparam logic [3:0] COL_EXT_LO   = 4'hB;
    localparam logic [3:0] COL_IMM_HI   = 4'hC;
    localparam logic [3:0] COL_DIR_HI   = 4'hD;
    localparam logic [3:0] COL_IDX_HI   = 4'hE;
    localparam logic [3:0] COL_EXT_HI   = 4'hF;
    localparam logic [3:0] IMM16_ROW    = 4'h3;
    localparam logic [3:0] IMM16_MIN    = 4'hC;

    // ********************************************************
    // postbyte fields
    // ********************************************************
    localparam int         PB_FORM5_BIT = 5;
    localparam int         PB_PRE_BIT   = 4;
    localparam int         PB_ACC_BIT   = 2;
    localparam int         PB_Z_BIT     = 1;
    localparam int         PB_S_BIT     = 0;
    localparam logic [2:0] PB_LONG_FORM = 3'h7;
    localparam logic [1:0] BASE_X       = 2'h0;
    localparam logic [1:0] BASE_Y       = 2'h1;
    localparam logic [1:0] BASE_SP      = 2'h2;
    localparam logic [1:0] BASE_PC      = 2'h3;
    localparam logic [1:0] ACC_A        = 2'h0;
    localparam logic [1:0] ACC_B        = 2'h1;
    localparam logic [1:0] ACC_D        = 2'h2;
    localparam logic [1:0] ACC_D_PTR    = 2'h3;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    localparam logic [15:0] ZERO_WORD   = 16'h0000;

    // ********************************************************
    // types
    // ********************************************************
    typedef enum logic [3:0] {
        no_operand_mode              = 4'h0,
        inline_value_mode            = 4'h1,
        page_zero_mode               = 4'h2,
        full_address_mode            = 4'h3,
        relative_mode                = 4'h4,
        register_offset_mode         = 4'h5,
        register_offset_one_ext_mode = 4'h6,
        register_offset_two_ext_mode = 4'h7,
        pointer_via_constant_mode    = 4'h8,
        pointer_via_double_acc_mode  = 4'h9,
        auto_adjust_mode             = 4'hA,
        acc_offset_mode              = 4'hB,
        transfer_mode                = 4'hC,
        loop_mode                    = 4'hD
    } amd_mode_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [7:0]  a;
        logic [7:0]  b;
    } amd_core_regs_t;

    typedef struct packed {
        amd_mode_t   mode;
        logic        ext_bytes_hi;
        logic        ext_bytes_lo;
        logic        has_post;
    } amd_class_t;

    typedef struct packed {
        amd_mode_t   mode;
        logic        page2;
        logic [7:0]  opcode;
        logic [7:0]  index_postbyte;
        logic [15:0] operand;
        logic [15:0] ea;
        logic        ea_valid;
        logic        wb_en;
        logic [1:0]  wb_sel;
        logic [15:0] wb_value;
    } amd_result_t;

    localparam amd_result_t RESULT_RESET = '0;

endpackage

// File: logic/amd_addr_adder.sv
`timescale 1ns/1ps
module amd_addr_adder #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] a,
    input  wire logic [WIDTH-1:0] b,
    output logic      [WIDTH-1:0] sum
);

    // ********************************************************
    // registered modulo adder
    // ********************************************************
    wire logic [WIDTH-1:0] next_sum = WIDTH'(a + b);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sum <= '0;
        end else begin
            sum <= next_sum;
        end
    end

endmodule

// File: logic/amd_decoder.sv
`timescale 1ns/1ps
// Behaviour
// (RULE1) no-operand opcodes read no operand bytes
// (RULE2) immediate operand from one or two following bytes
// (RULE3) direct: one address byte, high address byte forced to zero
// (RULE4) extended: two bytes, high first, form the full address
// (RULE5) relative: signed 8 or 16 bit displacement added to pc
// (RULE6) indexed: postbyte then zero to two extension bytes
// (RULE7) rr0nnnnn: signed 5-bit offset plus any of four bases
// (RULE8) 111rr0zs: 9-bit offset with sign in lsb, or 16-bit offset
// (RULE9) 111rr011: base plus 16-bit offset points to 16-bit pointer
// (RULE10) rr1pnnnn: step -8..-1 or +1..+8, before or after use
// (RULE11) auto adjust never uses pc as base
// (RULE12) 111rr1aa: unsigned accumulator offset a, b or double d
// (RULE13) 111rr111: base plus d points to 16-bit pointer
// (RULE14) opcode and page select the fetch sequence
// (RULE15) second-page prefix selects the second opcode page
// (RULE16) postbytes also for transfer and loop opcodes
// (RULE17) base code 00 x, 01 y, 10 sp, 11 pc
// (RULE18) words high byte first, any alignment
// (RULE19) full 16-bit base plus offset
module amd_decoder (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic [7:0]              in_byte,
    input  wire logic                    in_valid,
    output logic                         in_ready,
    input  wire amd_pkg::amd_core_regs_t core_regs,
    output logic                         mem_req,
    output logic [15:0]                  mem_addr,
    input  wire logic                    mem_ack,
    input  wire logic [7:0]              mem_rdata,
    output logic                         out_valid,
    output amd_pkg::amd_result_t         result
);

    // ********************
    // states
    // ********************
    typedef enum logic [5:0] {
        ST_OPC  = 6'h01,
        ST_POST = 6'h02,
        ST_EXT  = 6'h04,
        ST_CALC = 6'h08,
        ST_PTR  = 6'h10,
        ST_DONE = 6'h20
    } amd_state_t;

    amd_state_t        state;
    amd_state_t        next_state;
    amd_pkg::amd_mode_t mode;
    logic              page2;
    logic [7:0]        opcode;
    logic [7:0]        postbyte;
    logic [15:0]       ext_val;
    logic [1:0]        ext_left;
    logic [15:0]       base_val;
    logic [15:0]       ptr_val;
    logic              ptr_phase;
    logic [15:0]       sum_q;

    // ********************
    // functions
    // ********************
    function automatic amd_pkg::amd_class_t amd_classify(
        input logic       pg,
        input logic [7:0] opc
    );
        amd_pkg::amd_class_t c;
        logic                wide;
        c = '0;
        c.mode = amd_pkg::no_operand_mode;
        wide = (opc[3:0] == amd_pkg::IMM16_ROW)
            || (opc[3:0] >= amd_pkg::IMM16_MIN);
        if (opc == amd_pkg::XFER_OPCODE) begin
            c.mode     = amd_pkg::transfer_mode;
            c.has_post = 1'b1;
        end else if (opc == amd_pkg::LOOP_OPCODE) begin
            c.mode     = amd_pkg::loop_mode;
            c.has_post = 1'b1;
        end else begin
            unique case (opc[7:4])
                amd_pkg::COL_REL: begin
                    c.mode         = amd_pkg::relative_mode;
                    c.ext_bytes_hi = pg;
                    c.ext_bytes_lo = !pg;
                end
                amd_pkg::COL_IMM_LO, amd_pkg::COL_IMM_HI: begin
                    c.mode         = amd_pkg::inline_value_mode;
                    c.ext_bytes_hi = wide;
                    c.ext_bytes_lo = !wide;
                end
                amd_pkg::COL_DIR_LO, amd_pkg::COL_DIR_HI: begin
                    c.mode         = amd_pkg::page_zero_mode;
                    c.ext_bytes_lo = 1'b1;
                end
                amd_pkg::COL_EXT_LO, amd_pkg::COL_EXT_HI: begin
                    c.mode         = amd_pkg::full_address_mode;
                    c.ext_bytes_hi = 1'b1;
                end
                amd_pkg::COL_IDX_LO, amd_pkg::COL_IDX_HI: begin
                    c.mode     = amd_pkg::register_offset_mode;
                    c.has_post = 1'b1;
                end
                default: begin
                    c.mode = amd_pkg::no_operand_mode;
                end
            endcase
        end
        return c;
    endfunction

    function automatic amd_pkg::amd_class_t amd_post_decode(
        input logic [7:0] pb
    );
        amd_pkg::amd_class_t c;
        c = '0;
        c.has_post = 1'b1;
        if (!pb[amd_pkg::PB_FORM5_BIT]) begin
            c.mode = amd_pkg::register_offset_mode;
        end else if (pb[7:5] != amd_pkg::PB_LONG_FORM) begin
            c.mode = amd_pkg::auto_adjust_mode;
        end else if (pb[amd_pkg::PB_ACC_BIT]) begin
            c.mode = (pb[1:0] == amd_pkg::ACC_D_PTR)
                ? amd_pkg::pointer_via_double_acc_mode
                : amd_pkg::acc_offset_mode;
        end else if (!pb[amd_pkg::PB_Z_BIT]) begin
            c.mode         = amd_pkg::register_offset_one_ext_mode;
            c.ext_bytes_lo = 1'b1;
        end else begin
            c.mode = pb[amd_pkg::PB_S_BIT]
                ? amd_pkg::pointer_via_constant_mode
                : amd_pkg::register_offset_two_ext_mode;
            c.ext_bytes_hi = 1'b1;
        end
        return c;
    endfunction

    function automatic logic [15:0] amd_sext8(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction

    // ********************
    // decode wires
    // ********************
    wire logic take = in_valid && in_ready;
    wire logic is_prefix = (in_byte == amd_pkg::PAGE2_PREFIX) && !page2; // RULE15
    wire amd_pkg::amd_class_t op_cls = amd_classify(page2, in_byte); // RULE14
    wire amd_pkg::amd_class_t pb_cls = amd_post_decode(in_byte); // RULE6
    wire logic [1:0] op_ext = {op_cls.ext_bytes_hi, op_cls.ext_bytes_lo};
    wire logic [1:0] pb_ext = {pb_cls.ext_bytes_hi, pb_cls.ext_bytes_lo};
    wire logic is_index = (mode >= amd_pkg::register_offset_mode)
        && (mode <= amd_pkg::acc_offset_mode);
    wire logic needs_calc = is_index || (mode == amd_pkg::relative_mode)
        || (mode == amd_pkg::loop_mode);
    wire logic is_pointer = (mode == amd_pkg::pointer_via_constant_mode)
        || (mode == amd_pkg::pointer_via_double_acc_mode);

    // ********************
    // offset and base selection
    // ********************
    wire logic        long_pb  = postbyte[7:5] == amd_pkg::PB_LONG_FORM;
    wire logic [1:0]  base_sel = long_pb ? postbyte[4:3] : postbyte[7:6]; // RULE8
    wire logic [1:0]  acc_sel  = postbyte[1:0];
    wire logic [15:0] acc_d    = {core_regs.a, core_regs.b};
    wire logic [15:0] base_mux =
        (base_sel == amd_pkg::BASE_X)  ? core_regs.x  : // RULE17
        (base_sel == amd_pkg::BASE_Y)  ? core_regs.y  :
        (base_sel == amd_pkg::BASE_SP) ? core_regs.sp :
                                         core_regs.pc;
    wire logic [3:0]  step_n   = postbyte[3:0];
    wire logic [15:0] step     = step_n[3]
        ? {{12{1'b1}}, step_n} // RULE10
        : {12'h000, step_n} + 16'h0001; // RULE10
    wire logic [15:0] acc_ofs  =
        (acc_sel == amd_pkg::ACC_A) ? {amd_pkg::ZERO_BYTE, core_regs.a} : // RULE12
        (acc_sel == amd_pkg::ACC_B) ? {amd_pkg::ZERO_BYTE, core_regs.b} :
                                      acc_d; // RULE12 RULE13
    wire logic [15:0] idx_ofs  =
        (mode == amd_pkg::register_offset_mode)
            ? {{11{postbyte[4]}}, postbyte[4:0]} : // RULE7
        (mode == amd_pkg::register_offset_one_ext_mode)
            ? {{8{postbyte[amd_pkg::PB_S_BIT]}}, ext_val[7:0]} : // RULE8
        (mode == amd_pkg::auto_adjust_mode) ? step :
        (mode == amd_pkg::acc_offset_mode ||
         mode == amd_pkg::pointer_via_double_acc_mode) ? acc_ofs :
        ext_val; // RULE8 RULE9
    wire logic rel_long = (mode == amd_pkg::relative_mode) && page2;
    wire logic [15:0] rel_ofs = rel_long ? ext_val : amd_sext8(ext_val[7:0]);
    wire logic [15:0] add_a = is_index ? base_mux : core_regs.pc; // RULE5 RULE19
    wire logic [15:0] add_b = is_index ? idx_ofs : rel_ofs; // RULE5 RULE19

    amd_addr_adder #(
        .WIDTH (16)
    ) u_adder (
        .clk    (clk),
        .resetn (resetn),
        .a      (add_a),
        .b      (add_b),
        .sum    (sum_q)
    );

    // ********************
    // result assembly
    // ********************
    wire logic post_adjust = (mode == amd_pkg::auto_adjust_mode)
        && postbyte[amd_pkg::PB_PRE_BIT];
    wire logic [15:0] ea_mux =
        (mode == amd_pkg::page_zero_mode)
            ? {amd_pkg::ZERO_BYTE, ext_val[7:0]} : // RULE3
        (mode == amd_pkg::full_address_mode) ? ext_val : // RULE4
        is_pointer ? ptr_val : // RULE9 RULE13
        post_adjust ? base_val : // RULE10
        sum_q;
    wire logic ea_ok = needs_calc || (mode == amd_pkg::page_zero_mode)
        || (mode == amd_pkg::full_address_mode);
    amd_pkg::amd_result_t next_result;

    always_comb begin
        next_result = amd_pkg::RESULT_RESET;
        next_result.mode = mode;
        next_result.page2 = page2;
        next_result.opcode = opcode;
        next_result.index_postbyte = postbyte;
        next_result.operand = (mode == amd_pkg::inline_value_mode)
            ? ext_val : amd_pkg::ZERO_WORD; // RULE2 RULE1
        next_result.ea = ea_ok ? ea_mux : amd_pkg::ZERO_WORD;
        next_result.ea_valid = ea_ok;
        next_result.wb_en = (mode == amd_pkg::auto_adjust_mode); // RULE11
        next_result.wb_sel = base_sel;
        next_result.wb_value = next_result.wb_en ? sum_q : amd_pkg::ZERO_WORD;
    end

    // ********************
    // next state
    // ********************
    always_comb begin
        next_state = state;
        unique case (state)
            ST_OPC: begin
                if (take && !is_prefix) begin
                    if (op_cls.has_post) begin
                        next_state = ST_POST;
                    end else if (op_ext != 2'h0) begin
                        next_state = ST_EXT;
                    end else begin
                        next_state = ST_DONE; // RULE1
                    end
                end
            end
            ST_POST: begin
                if (take) begin
                    if (mode == amd_pkg::transfer_mode) begin
                        next_state = ST_DONE; // RULE16
                    end else if (mode == amd_pkg::loop_mode) begin
                        next_state = ST_EXT; // RULE16
                    end else if (pb_ext != 2'h0) begin
                        next_state = ST_EXT; // RULE6
                    end else begin
                        next_state = ST_CALC;
                    end
                end
            end
            ST_EXT: begin
                if (take && ext_left == 2'h1) begin
                    next_state = needs_calc ? ST_CALC : ST_DONE;
                end
            end
            ST_CALC: begin
                next_state = is_pointer ? ST_PTR : ST_DONE;
            end
            ST_PTR: begin
                if (mem_req && mem_ack && ptr_phase) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_OPC;
            end
        endcase
    end

    wire logic next_ready = (next_state == ST_OPC) || (next_state == ST_POST)
        || (next_state == ST_EXT);

    // ********************
    // registers
    // ********************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state    <= ST_OPC;
            in_ready <= 1'b0;
        end else begin
            state    <= next_state;
            in_ready <= next_ready;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode     <= amd_pkg::no_operand_mode;
            page2    <= 1'b0;
            opcode   <= 8'h00;
            postbyte <= 8'h00;
            ext_val  <= 16'h0000;
            ext_left <= 2'h0;
        end else if (state == ST_OPC && take) begin
            page2    <= is_prefix || page2; // RULE15
            opcode   <= in_byte;
            mode     <= op_cls.mode; // RULE14
            ext_left <= op_ext; // RULE2 RULE3 RULE4 RULE5
            postbyte <= 8'h00;
            ext_val  <= 16'h0000;
        end else if (state == ST_POST && take) begin
            postbyte <= in_byte; // RULE16
            if (mode == amd_pkg::loop_mode) begin
                ext_left <= 2'h1;
            end else if (mode != amd_pkg::transfer_mode) begin
                mode     <= pb_cls.mode; // RULE6
                ext_left <= pb_ext; // RULE6
            end
        end else if (state == ST_EXT && take) begin
            ext_val  <= {ext_val[7:0], in_byte}; // RULE18 RULE4
            ext_left <= 2'(ext_left - 2'h1);
        end else if (state == ST_DONE) begin
            page2 <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            base_val <= 16'h0000;
        end else if (state == ST_CALC) begin
            base_val <= base_mux; // RULE10
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_req   <= 1'b0;
            mem_addr  <= 16'h0000;
            ptr_phase <= 1'b0;
            ptr_val   <= 16'h0000;
        end else if (state == ST_PTR) begin
            if (!mem_req) begin
                mem_req  <= 1'b1;
                mem_addr <= 16'(sum_q + {15'h0000, ptr_phase}); // RULE18
            end else if (mem_ack) begin
                mem_req   <= 1'b0;
                ptr_val   <= {ptr_val[7:0], mem_rdata}; // RULE18 RULE9
                ptr_phase <= !ptr_phase;
            end
        end else begin
            mem_req   <= 1'b0;
            ptr_phase <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_valid <= 1'b0;
            result    <= amd_pkg::RESULT_RESET;
        end else begin
            out_valid <= (state == ST_DONE);
            if (state == ST_DONE) begin
                result <= next_result;
            end
        end
    end

endmodule

// File: testbench/amd_asserts.sv
`timescale 1ns/1ps
module amd_asserts (
    input wire logic                    clk,
    input wire logic                    resetn,
    input wire logic [7:0]              in_byte,
    input wire logic                    in_valid,
    input wire logic                    in_ready,
    input wire amd_pkg::amd_core_regs_t core_regs,
    input wire logic                    mem_req,
    input wire logic [15:0]             mem_addr,
    input wire logic                    mem_ack,
    input wire logic [7:0]              mem_rdata,
    input wire logic                    out_valid,
    input wire amd_pkg::amd_result_t    result
);
    // ********************************************************
    // output checks
    // ********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_inh_no_ea: assert property (
        out_valid && result.mode == amd_pkg::no_operand_mode
        |-> !result.ea_valid && !result.wb_en)
        else $error("inherent has address");
    chk_imm_no_ea: assert property (
        out_valid && result.mode == amd_pkg::inline_value_mode
        |-> !result.ea_valid) else $error("immediate has address");
    chk_dir_high_zero: assert property (
        out_valid && result.mode == amd_pkg::page_zero_mode
        |-> result.ea_valid && result.ea[15:8] == 8'h00)
        else $error("direct high byte");
    chk_short_form: assert property (
        out_valid && result.mode == amd_pkg::register_offset_mode
        |-> !result.index_postbyte[5]) else $error("short offset form");
    chk_auto_base: assert property (
        out_valid && result.mode == amd_pkg::auto_adjust_mode
        |-> result.wb_en && result.wb_sel == result.index_postbyte[7:6]
        && result.wb_sel != amd_pkg::BASE_PC
        && (result.index_postbyte[4] != (result.ea == result.wb_value)))
        else $error("auto adjust");
    chk_ptr_form: assert property (
        out_valid && result.mode == amd_pkg::pointer_via_constant_mode
        |-> result.index_postbyte[7:5] == 3'h7
        && result.index_postbyte[2:0] == 3'h3) else $error("pointer form");
    chk_mem_hold: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("read dropped");
    chk_ptr_second: assert property (
        mem_req && mem_ack ##1 !mem_req ##1 mem_req
        |-> mem_addr == $past(mem_addr, 2) + 16'h0001)
        else $error("second address");
    chk_out_single: assert property (
        out_valid |=> !out_valid) else $error("pulse long");
    chk_ready_busy: assert property (
        mem_req |-> !in_ready) else $error("ready in read");
endmodule

// File: testbench/amd_mem_model.sv
`timescale 1ns/1ps
module amd_mem_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic             mem_ack,
    output logic [7:0]       mem_rdata
);
    // ********************************************************
    // pointer memory, prompt or four cycles late
    // ********************************************************
    logic [2:0] wait_cnt;
    logic       go;
    assign go = mem_req && !mem_ack && (!slow || wait_cnt == 3'h4);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 8'h00;
            wait_cnt  <= 3'h0;
        end else if (go) begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'hA5;
            wait_cnt  <= 3'h0;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 3'h1 : 3'h0;
        end
    end
endmodule

// File: testbench/addressing_mode_decoder_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, g); fails++; end end
module addressing_mode_decoder_bench;
    logic                    clk, resetn, in_valid, in_ready, slow;
    logic                    mem_req, mem_ack, out_valid, e_wb_ok;
    logic [7:0]              in_byte, mem_rdata;
    logic [15:0]             mem_addr, seed, e_ea, w, e_wb;
    amd_pkg::amd_core_regs_t core_regs;
    amd_pkg::amd_result_t    result;
    amd_pkg::amd_mode_t      e_mode;
    logic [7:0]              q[$];
    logic [7:0]              pbs[14] = '{8'h10, 8'h0F, 8'hC0, 8'h27, 8'h28,
        8'h3F, 8'h6C, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hF6, 8'hFF};
    int                      fails, checks, n_ext;
    amd_decoder dut (.clk, .resetn, .in_byte, .in_valid, .in_ready,
        .core_regs, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .out_valid,
        .result);
    amd_mem_model u_mem (.clk, .resetn, .slow, .mem_req, .mem_addr,
        .mem_ack, .mem_rdata);
    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    function automatic logic [7:0] mb(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    function automatic logic [15:0] base_of(input logic [1:0] s);
        return s == 2'h0 ? core_regs.x : s == 2'h1 ? core_regs.y :
            s == 2'h2 ? core_regs.sp : core_regs.pc;
    endfunction
    task automatic expect_idx(input logic [7:0] pb);
        logic [15:0] bs, st, d;
        bs = base_of(pb[7:5] == 3'h7 ? pb[4:3] : pb[7:6]);
        st = pb[3] ? {12'hFFF, pb[3:0]} : {12'h000, pb[3:0]} + 16'h1;
        d = {core_regs.a, core_regs.b};
        n_ext = 0;
        e_wb_ok = 1'b0;
        if (!pb[5]) begin
            e_mode = amd_pkg::register_offset_mode;
            e_ea = bs + {{11{pb[4]}}, pb[4:0]};
        end else if (pb[7:5] != 3'h7) begin
            e_mode = amd_pkg::auto_adjust_mode;
            e_wb_ok = 1'b1;
            e_wb = bs + st;
            e_ea = pb[4] ? bs : bs + st;
        end else if (pb[1:0] == 2'h3) begin
            e_mode = pb[2] ? amd_pkg::pointer_via_double_acc_mode :
                amd_pkg::pointer_via_constant_mode;
            n_ext = pb[2] ? 0 : 2;
            e_ea = pb[2] ? bs + d : bs + w;
            e_ea = {mb(e_ea), mb(e_ea + 16'h1)};
        end else if (pb[2]) begin
            e_mode = amd_pkg::acc_offset_mode;
            e_ea = bs + (pb[1] ? d : {8'h00, pb[0] ? core_regs.b : core_regs.a});
        end else begin
            e_mode = pb[1] ? amd_pkg::register_offset_two_ext_mode :
                amd_pkg::register_offset_one_ext_mode;
            n_ext = pb[1] ? 2 : 1;
            e_ea = bs + (pb[1] ? w : {{8{pb[0]}}, w[15:8]});
        end
    endtask
    task automatic run(input logic [7:0] b[$], input amd_pkg::amd_mode_t m,
                       input logic [15:0] v, input logic ck);
        int k;
        foreach (b[i]) begin
            in_byte = b[i];
            in_valid = 1'b1;
            for (k = 0; k < 50 && in_ready !== 1'b1; k++) @(negedge clk);
            @(negedge clk);
        end
        in_valid = 1'b0;
        in_byte = ~in_byte;
        for (k = 0; k < 50 && out_valid !== 1'b1; k++) @(negedge clk);
        `CHK("mode", m, result.mode)
        `CHK("page2", b[0] == 8'h18, result.page2)
        `CHK("ea_valid", ck, result.ea_valid)
        if (m == amd_pkg::inline_value_mode) `CHK("operand", v, result.operand)
        else if (ck) `CHK("ea", v, result.ea)
    endtask
    task automatic idx(input logic [7:0] pb);
        core_regs = {rnd(), rnd(), rnd(), rnd(), rnd()};
        w = rnd();
        slow = w[3];
        expect_idx(pb);
        q = '{8'hA6, pb};
        if (n_ext > 0) q.push_back(w[15:8]);
        if (n_ext > 1) q.push_back(w[7:0]);
        run(q, e_mode, e_ea, 1'b1);
        if (e_wb_ok) `CHK("wb_value", e_wb, result.wb_value)
    endtask
    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ********************************************************
    // sequence
    // ********************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        test_done();
    end
    initial begin
        {resetn, in_valid, in_byte, slow, fails, checks} = '0;
        seed = 16'h0018;
        core_regs = {rnd(), rnd(), rnd(), rnd(), rnd()};
        repeat (4) @(negedge clk);
        `CHK("idle", 3'h0, {in_ready, mem_req, out_valid})
        @(negedge clk) resetn = 1'b1;
        @(negedge clk);
        $display("test reset done");
        run('{8'h40}, amd_pkg::no_operand_mode, 16'h0, 1'b0);
        run('{8'h86, 8'h5C}, amd_pkg::inline_value_mode, 16'h005C, 1'b0);
        run('{8'h83, 8'h12, 8'h34}, amd_pkg::inline_value_mode, 16'h1234, 1'b0);
        run('{8'h96, 8'hF3}, amd_pkg::page_zero_mode, 16'h00F3, 1'b1);
        run('{8'hB6, 8'h12, 8'h34}, amd_pkg::full_address_mode, 16'h1234, 1'b1);
        run('{8'h20, 8'h80}, amd_pkg::relative_mode, core_regs.pc - 16'h80, 1'b1);
        run('{8'h18, 8'h20, 8'h7F, 8'hFE}, amd_pkg::relative_mode,
            core_regs.pc + 16'h7FFE, 1'b1);
        run('{8'h18, 8'h18}, amd_pkg::no_operand_mode, 16'h0, 1'b0);
        run('{8'h18, 8'hB6, 8'hAB, 8'hCD}, amd_pkg::full_address_mode,
            16'hABCD, 1'b1);
        run('{8'h1E, 8'h89}, amd_pkg::transfer_mode, 16'h0, 1'b0);
        run('{8'h1F, 8'h25, 8'h10}, amd_pkg::loop_mode,
            core_regs.pc + 16'h10, 1'b1);
        $display("test fixed modes done");
        foreach (pbs[i]) idx(pbs[i]);
        $display("test index corners done");
        repeat (60) idx(rnd());
        $display("test random index done");
        test_done();
    end
endmodule
bind amd_decoder amd_asserts u_chk (.clk, .resetn, .in_byte, .in_valid,
    .in_ready, .core_regs, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
    .out_valid, .result);
